/* File: hdl/dbf_input_path.sv */
// Byte-wide DDR receive path with elastic buffer, alarms, pattern checker and clock monitor
// Functional notes
// - 8-bit bus carries two 16-bit samples
// - Byte on both edges; four make I/Q
// - Frame marker sampled on rising edges only
// - Buffer holds eight two-channel samples
// - Write/read at pointers, read per output tick
// - Reset: write pointer 0, read at offset
// - Read reset position set by 3-bit field
// - Frame marker rise resets both pointers
// - Resync disabled: only first frame resets
// - Gap-two, gap-one and collision alarms
// - Alarms shown in status and alarm pin
// - Buffer enable off selects direct bypass
// - Bypass: pointers do not affect data
// - Pattern check mutes analog outputs
// - Eight-word key, first word at frame
// - Per-word mismatch bits set pattern alarm
// - Pattern alarm sticky, or 64-good auto-clear
// - Clock lost after four idle cycles
// - Clock loss sets lost and muted; mid-scale
// - Masks gate clock alarms at the pin only; enables disable them
// - Clock alarms cleared only by their clear inputs
`timescale 1ns/1ps
module dbf_input_path #(
  parameter int DEPTH = dbf_pkg::BUF_DEPTH,
  parameter int LOST_CYCLES = dbf_pkg::CLK_LOST_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Link from the data source
  input wire logic input_sample_clock,
  input wire logic [7:0] data_byte,
  input wire logic frame_marker,
  // Buffer configuration
  input wire logic buffer_enable,
  input wire logic pointer_resync_enable,
  input wire logic multi_sync_enable,
  input wire logic [2:0] read_pointer_offset,
  input wire logic [dbf_pkg::INTERP_W-1:0] interp_factor,
  // Pattern checker configuration
  input wire logic pattern_check_enable,
  input wire logic good_sample_auto_clear_enable,
  input wire logic pattern_alarm_clear,
  input wire logic [dbf_pkg::KEY_WORDS-1:0][dbf_pkg::SAMPLE_W-1:0] pattern_key,
  // Clock monitor configuration
  input wire logic clock_lost_enable,
  input wire logic output_muted_enable,
  input wire logic clock_lost_mask,
  input wire logic output_muted_mask,
  input wire logic clock_lost_clear,
  input wire logic output_muted_clear,
  // Output stream to the conversion logic
  input wire logic transmit_gate,
  output dbf_pkg::dbf_sample_type out_sample,
  output logic out_valid,
  input wire logic out_ready,
  output logic analog_enable,
  // Status
  output dbf_pkg::dbf_fifo_alarm_type fifo_alarm,
  output logic pattern_error_alarm,
  output logic [dbf_pkg::KEY_WORDS-1:0] pattern_mismatch,
  output dbf_pkg::dbf_clock_alarm_type clock_alarm,
  output logic alarm_or_serial_out_pin
);
  // Ring distance between two pointers, whichever way round
  function automatic logic [2:0] ptr_distance(input logic [2:0] a, input logic [2:0] b);
    logic [2:0] fwd;
    logic [2:0] back;
    fwd = a - b;
    back = b - a;
    ptr_distance = (fwd < back) ? fwd : back;
  endfunction : ptr_distance

  // Link capture registers
  logic isc_q;
  logic isc_prev_q;
  logic [7:0] byte_q;
  logic frame_in_q;
  logic frame_s_q;
  logic isc_rise;
  logic isc_edge;
  logic frame_start;
  // Assembly
  logic [dbf_pkg::BYTE_IDX_W-1:0] byte_idx_q;
  logic [dbf_pkg::BYTE_IDX_W-1:0] byte_idx_use;
  logic [dbf_pkg::SAMPLE_W-1:0] asm_q;
  logic first_pending_q;
  dbf_pkg::dbf_sample_type sample_q;
  logic sample_done_q;
  logic sample_first_q;
  logic first_frame_seen_q;
  // Elastic buffer
  dbf_pkg::dbf_sample_type mem_q [DEPTH];
  logic [dbf_pkg::PTR_W-1:0] wr_ptr_q;
  logic [dbf_pkg::PTR_W-1:0] rd_ptr_q;
  dbf_pkg::dbf_sample_type bypass_q;
  logic ptr_reset;
  logic [2:0] gap;
  // Output tick and handoff
  logic [dbf_pkg::INTERP_W-1:0] div_cnt_q;
  logic out_tick_q;
  logic buf_in_ready;
  logic push;
  dbf_pkg::dbf_sample_type push_data;
  // Pattern checker
  logic [2:0] key_idx_q;
  logic [2:0] key_idx_use;
  logic [6:0] good_cnt_q;
  logic word_bad;
  logic check_now;
  logic auto_clear;
  // Clock monitor
  logic [dbf_pkg::IDLE_W-1:0] idle_cnt_q;
  logic clk_stopped;

  // Clock level and byte are registered together, so the byte seen at a level change is the edge's byte
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      isc_q <= 1'b0;
      isc_prev_q <= 1'b0;
      byte_q <= 8'h00;
      frame_in_q <= 1'b0;
    end else begin
      isc_q <= input_sample_clock;
      isc_prev_q <= isc_q;
      byte_q <= data_byte;
      frame_in_q <= frame_marker;
    end
  end

  assign isc_rise = isc_q & ~isc_prev_q;
  assign isc_edge = isc_q ^ isc_prev_q;
  assign frame_start = isc_rise & frame_in_q & ~frame_s_q;

  // Frame marker is looked at only on rising input clock edges
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      frame_s_q <= 1'b0;
    end else if (isc_rise) begin
      frame_s_q <= frame_in_q;
    end
  end

  // A frame start forces the byte onto the first slot of a new sample
  assign byte_idx_use = frame_start ? '0 : byte_idx_q;

  // Byte assembly: I high, I low, Q high, Q low
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      byte_idx_q <= '0;
      asm_q <= '0;
      first_pending_q <= 1'b0;
      sample_q <= '0;
      sample_done_q <= 1'b0;
      sample_first_q <= 1'b0;
    end else begin
      sample_done_q <= 1'b0;
      if (isc_edge) begin
        byte_idx_q <= byte_idx_use + 2'h1;
        asm_q[dbf_pkg::SAMPLE_W-1-8*byte_idx_use -: 8] <= byte_q;
        if (frame_start) begin
          first_pending_q <= 1'b1;
        end
        if (byte_idx_use == 2'h3) begin
          sample_q <= {asm_q[dbf_pkg::SAMPLE_W-1:8], byte_q};
          sample_done_q <= 1'b1;
          sample_first_q <= first_pending_q;
          first_pending_q <= 1'b0;
        end
      end
    end
  end

  // After the first frame, further frames reset pointers only when resync is on
  assign ptr_reset = frame_start & (pointer_resync_enable | ~first_frame_seen_q);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      first_frame_seen_q <= 1'b0;
    end else if (frame_start) begin
      first_frame_seen_q <= 1'b1;
    end
  end

  // Output clock enable: conversion clock divided by interpolation
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      div_cnt_q <= '0;
      out_tick_q <= 1'b0;
    end else if (div_cnt_q + 3'h1 >= interp_factor) begin
      div_cnt_q <= '0;
      out_tick_q <= 1'b1;
    end else begin
      div_cnt_q <= div_cnt_q + 3'h1;
      out_tick_q <= 1'b0;
    end
  end

  // Buffer storage, written at the write pointer
  always_ff @(posedge mclk) begin
    if (sample_done_q && buffer_enable) begin
      mem_q[wr_ptr_q] <= sample_q;
    end
  end

  // Bypass holds the latest sample for a direct handoff
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bypass_q <= '0;
    end else if (sample_done_q) begin
      bypass_q <= sample_q;
    end
  end

  // A read stalls while the downstream buffer is full, so no word is lost there
  assign push = out_tick_q & buf_in_ready;

  // Pointers wrap modulo eight; in bypass only a frame start reset moves them
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      wr_ptr_q <= dbf_pkg::WR_PTR_RESET;
      rd_ptr_q <= read_pointer_offset;
    end else if (ptr_reset) begin
      wr_ptr_q <= dbf_pkg::WR_PTR_RESET;
      rd_ptr_q <= read_pointer_offset;
    end else if (buffer_enable) begin
      if (sample_done_q) begin
        wr_ptr_q <= wr_ptr_q + 3'h1;
      end
      if (push) begin
        rd_ptr_q <= rd_ptr_q + 3'h1;
      end
    end
  end

  // Muted output carries mid-scale; bypass ignores the pointers entirely
  always_comb begin
    if (clock_alarm.output_muted) begin
      push_data = '{i: dbf_pkg::MID_SCALE, q: dbf_pkg::MID_SCALE};
    end else if (buffer_enable) begin
      push_data = mem_q[rd_ptr_q];
    end else begin
      push_data = bypass_q;
    end
  end

  dbf_skid_buffer #(
    .WIDTH(dbf_pkg::SAMPLE_W)
  ) u_out_buffer (
    .mclk(mclk),
    .resetn(resetn),
    .in_valid(out_tick_q),
    .in_data(push_data),
    .in_ready(buf_in_ready),
    .out_valid(out_valid),
    .out_data(out_sample),
    .out_ready(out_ready)
  );

  // Proximity alarms follow the pointers live; silent in bypass
  assign gap = ptr_distance(wr_ptr_q, rd_ptr_q);
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      fifo_alarm <= '0;
    end else begin
      fifo_alarm.gap_two <= buffer_enable & (gap <= dbf_pkg::GAP_TWO);
      fifo_alarm.gap_one <= buffer_enable & (gap <= dbf_pkg::GAP_ONE);
      fifo_alarm.collision <= buffer_enable & (gap == 3'h0);
    end
  end

  // Key word selection restarts at the sample that carried the frame start
  assign key_idx_use = sample_first_q ? 3'h0 : key_idx_q;
  assign check_now = sample_done_q & pattern_check_enable & (first_frame_seen_q | sample_first_q);
  assign word_bad = sample_q != pattern_key[key_idx_use];
  assign auto_clear = good_sample_auto_clear_enable & check_now & ~word_bad &
    (good_cnt_q + 7'h1 >= dbf_pkg::GOOD_RUN);

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      key_idx_q <= 3'h0;
      good_cnt_q <= 7'h00;
    end else if (check_now) begin
      key_idx_q <= key_idx_use + 3'h1;
      good_cnt_q <= (word_bad || auto_clear) ? 7'h00 : good_cnt_q + 7'h1;
    end
  end

  // Mismatch bits and alarm are sticky; a new error wins over a clear
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pattern_mismatch <= '0;
      pattern_error_alarm <= 1'b0;
    end else if (check_now && word_bad) begin
      pattern_mismatch[key_idx_use] <= 1'b1;
      pattern_error_alarm <= 1'b1;
    end else if (pattern_alarm_clear || auto_clear) begin
      pattern_mismatch <= '0;
      pattern_error_alarm <= 1'b0;
    end
  end

  // Count conversion cycles without any input clock edge
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      idle_cnt_q <= '0;
    end else if (isc_edge) begin
      idle_cnt_q <= '0;
    end else if (!clk_stopped) begin
      idle_cnt_q <= idle_cnt_q + 3'h1;
    end
  end

  assign clk_stopped = idle_cnt_q >= 3'(LOST_CYCLES);

  // Clock alarms stay until cleared; while the clock is still missing the set wins over a clear in the same cycle
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      clock_alarm <= '0;
    end else begin
      if (clk_stopped && clock_lost_enable) begin
        clock_alarm.clock_lost <= 1'b1;
      end else if (clock_lost_clear) begin
        clock_alarm.clock_lost <= 1'b0;
      end
      if (clk_stopped && output_muted_enable) begin
        clock_alarm.output_muted <= 1'b1;
      end else if (output_muted_clear) begin
        clock_alarm.output_muted <= 1'b0;
      end
    end
  end

  // Analog gate and shared alarm pin
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      analog_enable <= 1'b0;
      alarm_or_serial_out_pin <= 1'b0;
    end else begin
      analog_enable <= transmit_gate & ~pattern_check_enable & ~clock_alarm.output_muted;
      alarm_or_serial_out_pin <= (|fifo_alarm) | pattern_error_alarm |
        (clock_alarm.clock_lost & ~clock_lost_mask) |
        (clock_alarm.output_muted & ~output_muted_mask);
    end
  end
endmodule : dbf_input_path

/* File: hdl/dbf_pkg.sv */
// Shared constants and carrier types of the byte-wide input path
package dbf_pkg;
  // Bus and sample geometry
  localparam int BYTE_W = 8;
  localparam int CHAN_W = 16;
  localparam int SAMPLE_W = 2 * CHAN_W;
  localparam int BYTES_PER_SAMPLE = 4;
  localparam int BYTE_IDX_W = 2;
  // Elastic buffer geometry and pointer reset positions
  localparam int BUF_DEPTH = 8;
  localparam int PTR_W = 3;
  localparam logic [2:0] WR_PTR_RESET = 3'h0;
  localparam logic [2:0] RD_PTR_RESET_DEFAULT = 3'h4;
  // Pointer proximity thresholds, in addresses
  localparam logic [2:0] GAP_TWO = 3'h2;
  localparam logic [2:0] GAP_ONE = 3'h1;
  // Pattern checker key length and auto-clear run length
  localparam int KEY_WORDS = 8;
  localparam logic [6:0] GOOD_RUN = 7'h40;
  // Clock monitor: stopped input clock, in conversion clock cycles
  localparam int CLK_LOST_CYCLES = 4;
  localparam int IDLE_W = 3;
  // Output divider width for the interpolation factor
  localparam int INTERP_W = 3;
  // Mid-scale code for two's complement channel data
  localparam logic [15:0] MID_SCALE = 16'h0000;

  // One assembled I/Q sample
  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } dbf_sample_type;

  // Pointer proximity alarms
  typedef struct packed {
    logic gap_two;
    logic gap_one;
    logic collision;
  } dbf_fifo_alarm_type;

  // Clock monitor alarms
  typedef struct packed {
    logic clock_lost;
    logic output_muted;
  } dbf_clock_alarm_type;
endpackage : dbf_pkg

/* File: hdl/dbf_skid_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module dbf_skid_buffer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  logic [WIDTH-1:0] head_q;
  logic [WIDTH-1:0] tail_q;
  logic head_v_q;
  logic tail_v_q;
  logic push;
  logic pop;

  // Ready only depends on the spare entry, so no combinational path from out_ready
  assign in_ready = ~tail_v_q;
  assign out_valid = head_v_q;
  assign out_data = head_q;
  assign push = in_valid & ~tail_v_q;
  assign pop = head_v_q & out_ready;

  // Head and tail update
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      head_q <= '0;
      tail_q <= '0;
      head_v_q <= 1'b0;
      tail_v_q <= 1'b0;
    end else if (pop) begin
      if (tail_v_q) begin
        head_q <= tail_q;
        tail_v_q <= push;
        if (push) begin
          tail_q <= in_data;
        end
      end else begin
        head_v_q <= push;
        if (push) begin
          head_q <= in_data;
        end
      end
    end else if (push) begin
      if (!head_v_q) begin
        head_q <= in_data;
        head_v_q <= 1'b1;
      end else begin
        tail_q <= in_data;
        tail_v_q <= 1'b1;
      end
    end
  end
endmodule : dbf_skid_buffer

/* File: verification/dbf_props.sv */
// Checker of the receive path port behaviour
`timescale 1ns/1ps
module dbf_props #(
  parameter int LOST_CYCLES = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Watched inputs
  input wire logic input_sample_clock,
  input wire logic buffer_enable,
  input wire logic pattern_check_enable,
  input wire logic good_sample_auto_clear_enable,
  input wire logic pattern_alarm_clear,
  input wire logic clock_lost_enable,
  input wire logic clock_lost_clear,
  input wire logic clock_lost_mask,
  input wire logic out_ready,
  // Watched outputs
  input wire dbf_pkg::dbf_sample_type out_sample,
  input wire logic out_valid,
  input wire logic analog_enable,
  input wire dbf_pkg::dbf_fifo_alarm_type fifo_alarm,
  input wire logic pattern_error_alarm,
  input wire dbf_pkg::dbf_clock_alarm_type clock_alarm,
  input wire logic alarm_or_serial_out_pin
);
  logic isc_q;
  logic [3:0] idle_q;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Cycles without a link clock change; margin covers input registering
  always_ff @(posedge mclk) begin
    isc_q <= input_sample_clock;
    if (!resetn || isc_q != input_sample_clock || !clock_lost_enable) idle_q <= 4'h0;
    else if (idle_q != 4'hf) idle_q <= idle_q + 4'h1;
  end
  reset_quiet_a: assert property ($rose(resetn) |-> !out_valid && clock_alarm == 2'h0) else $error("outputs not clear");
  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_sample)) else $error("word lost");
  alarm_nest_a: assert property (fifo_alarm.collision |-> fifo_alarm.gap_one && fifo_alarm.gap_two) else $error("nest");
  fifo_pin_a: assert property (fifo_alarm != 3'h0 |=> alarm_or_serial_out_pin) else $error("fifo alarm not on pin");
  bypass_quiet_a: assert property (!buffer_enable ##1 !buffer_enable |-> fifo_alarm == 3'h0) else $error("bypass alarm");
  test_mute_a: assert property (pattern_check_enable |=> !analog_enable) else $error("analog on in test");
  muted_off_a: assert property (clock_alarm.output_muted |=> !analog_enable) else $error("analog on while muted");
  pat_sticky_a: assert property (pattern_error_alarm && !pattern_alarm_clear && !good_sample_auto_clear_enable
    |=> pattern_error_alarm) else $error("pattern alarm dropped");
  lost_set_a: assert property (idle_q == 4'(LOST_CYCLES + 4) |-> clock_alarm.clock_lost) else $error("loss missed");
  lost_off_a: assert property (!clock_lost_enable && !clock_alarm.clock_lost |=> !clock_alarm.clock_lost)
    else $error("disabled alarm set");
  lost_pin_a: assert property (clock_alarm.clock_lost && !clock_lost_mask |=> alarm_or_serial_out_pin)
    else $error("loss not on pin");
  lost_sticky_a: assert property (clock_alarm.clock_lost && !clock_lost_clear |=> clock_alarm.clock_lost)
    else $error("loss dropped");
endmodule : dbf_props

bind dbf_input_path dbf_props #(.LOST_CYCLES(LOST_CYCLES)) i_props (.mclk, .resetn, .input_sample_clock,
  .buffer_enable, .pattern_check_enable, .good_sample_auto_clear_enable, .pattern_alarm_clear, .clock_lost_enable,
  .clock_lost_clear, .clock_lost_mask, .out_ready, .out_sample, .out_valid, .analog_enable, .fifo_alarm,
  .pattern_error_alarm, .clock_alarm, .alarm_or_serial_out_pin);

/* File: verification/dbf_source.sv */
// Data source model driving the byte-wide double-rate link
`timescale 1ns/1ps
module dbf_source (
  // Clock
  input wire logic mclk,
  // Link toward the receive path
  output logic input_sample_clock,
  output logic [7:0] data_byte,
  output logic frame_marker
);
  initial begin
    input_sample_clock = 1'b0;
    data_byte = 8'h00;
    frame_marker = 1'b0;
  end
  // One sample in four phases of two cycles; clock parks low after it
  task automatic send(input dbf_pkg::dbf_sample_type s, input logic frame);
    for (int k = 0; k < 4; k++) begin
      @(negedge mclk);
      input_sample_clock = ~input_sample_clock;
      data_byte = s[31-8*k -: 8];
      frame_marker = frame && (k < 2);
      @(negedge mclk);
    end
    // Parked link must not show the last byte
    @(negedge mclk);
    data_byte = ~data_byte;
  endtask : send
endmodule : dbf_source

/* File: verification/tb.sv */
// Self-checking bench of the byte-wide receive path
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic isc, frame, oval, aen, perr, pin;
  logic [7:0] dbyte, pmis;
  logic buf_en = 1'b1, resync_en = 1'b1, msync_en = 1'b1, pat_en = 1'b0, auto_clr = 1'b0, pat_clr = 1'b0;
  logic [2:0] rd_off = 3'h4;
  logic [2:0] interp = 3'h1;
  logic [dbf_pkg::KEY_WORDS-1:0][dbf_pkg::SAMPLE_W-1:0] key;
  logic lost_en = 1'b0, mute_en = 1'b0, lost_msk = 1'b0, mute_msk = 1'b0, lost_clr = 1'b0, mute_clr = 1'b0;
  logic tx_gate = 1'b1, rdy = 1'b1;
  dbf_pkg::dbf_sample_type osamp;
  dbf_pkg::dbf_fifo_alarm_type falm;
  dbf_pkg::dbf_clock_alarm_type calm;
  int num_errors = 0;
  int checks = 0;
  // Conversion clock, 100 ns
  always #50 mclk = ~mclk;
  dbf_source i_src (.mclk(mclk), .input_sample_clock(isc), .data_byte(dbyte), .frame_marker(frame));
  dbf_input_path i_dut (.mclk(mclk), .resetn(resetn), .input_sample_clock(isc), .data_byte(dbyte),
    .frame_marker(frame), .buffer_enable(buf_en), .pointer_resync_enable(resync_en), .multi_sync_enable(msync_en),
    .read_pointer_offset(rd_off), .interp_factor(interp), .pattern_check_enable(pat_en),
    .good_sample_auto_clear_enable(auto_clr), .pattern_alarm_clear(pat_clr), .pattern_key(key),
    .clock_lost_enable(lost_en), .output_muted_enable(mute_en), .clock_lost_mask(lost_msk),
    .output_muted_mask(mute_msk), .clock_lost_clear(lost_clr), .output_muted_clear(mute_clr),
    .transmit_gate(tx_gate), .out_sample(osamp), .out_valid(oval), .out_ready(rdy), .analog_enable(aen),
    .fifo_alarm(falm), .pattern_error_alarm(perr), .pattern_mismatch(pmis), .clock_alarm(calm),
    .alarm_or_serial_out_pin(pin));
  task automatic stop_test();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  task automatic settle(input int n);
    repeat (n) @(negedge mclk);
  endtask : settle
  // Eight key words after a frame start, word bad spoilt (none when bad is 8)
  task automatic send_frame(input int bad);
    for (int n = 0; n < 8; n++) i_src.send(key[n] ^ {31'h0, n == bad}, n == 0);
    settle(8);
  endtask : send_frame
  // Bounded wait for a given word at the output
  task automatic wait_sample(input logic [31:0] exp);
    int k;
    for (k = 0; k < 50 && !(oval === 1'b1 && osamp === exp); k++) @(negedge mclk);
    check("output word", exp, osamp);
    if (k == 50) stop_test();
  endtask : wait_sample
  initial begin
    int k;
    for (int n = 0; n < 8; n++) key[n] = {8'ha5, 8'(n), 8'h3c, 8'(n)};
    settle(12);
    resetn = 1'b1;
    settle(2);
    check("analog on", 1'b1, aen);
    pat_en = 1'b1;
    settle(2);
    check("analog off", 1'b0, aen);
    // Clean frame, then one bad word marks its own position
    send_frame(8);
    check("mismatch clean", 8'h00, pmis);
    send_frame(3);
    check("mismatch word3", 8'h08, pmis);
    check("pattern alarm", 1'b1, perr);
    // Auto-clear only after a full run of good words
    auto_clr = 1'b1;
    repeat (7) send_frame(8);
    check("alarm short run", 1'b1, perr);
    send_frame(8);
    check("alarm full run", 9'h000, {perr, pmis});
    auto_clr = 1'b0;
    send_frame(5);
    check("mismatch word5", 9'h120, {perr, pmis});
    pat_clr = 1'b1;
    settle(1);
    pat_clr = 1'b0;
    settle(2);
    check("manual clear", 9'h000, {perr, pmis});
    pat_en = 1'b0;
    // Reads with no writes drive the pointers together
    for (k = 0; k < 40 && falm.collision !== 1'b1; k++) @(negedge mclk);
    check("collision", 1'b1, falm.collision);
    if (k == 40) stop_test();
    // Reads sweep the whole ring, so a stored key word must come out
    wait_sample(key[6]);
    // Stalled reads freeze the read pointer; a frame start puts it at the programmed offset
    rd_off = 3'h1;
    rdy = 1'b0;
    settle(3);
    i_src.send(key[0], 1'b1);
    settle(3);
    check("offset gap", 3'h7, falm);
    // With resync off a later frame leaves the pointers alone
    resync_en = 1'b0;
    i_src.send(key[1], 1'b1);
    settle(3);
    check("single resync gap", 3'h6, falm);
    resync_en = 1'b1;
    rdy = 1'b1;
    // Bypass: assembled word straight through, stall loses nothing
    buf_en = 1'b0;
    i_src.send(32'h1234abcd, 1'b0);
    wait_sample(32'h1234abcd);
    rdy = 1'b0;
    settle(10);
    rdy = 1'b1;
    wait_sample(32'h1234abcd);
    // Stopped link clock raises both flags and mutes the data
    lost_en = 1'b1;
    mute_en = 1'b1;
    settle(12);
    check("clock flags", 2'h3, calm);
    check("analog muted", 1'b0, aen);
    check("alarm pin", 1'b1, pin);
    wait_sample(32'h00000000);
    lost_msk = 1'b1;
    mute_msk = 1'b1;
    settle(2);
    check("masked pin", 1'b0, pin);
    i_src.send(32'h0f0f0f0f, 1'b0);
    check("sticky flags", 2'h3, calm);
    // A clear while the clock is still missing loses to the set
    settle(8);
    lost_clr = 1'b1;
    mute_clr = 1'b1;
    settle(1);
    lost_clr = 1'b0;
    mute_clr = 1'b0;
    settle(2);
    check("clear while stopped", 2'h3, calm);
    lost_en = 1'b0;
    mute_en = 1'b0;
    lost_clr = 1'b1;
    mute_clr = 1'b1;
    settle(1);
    lost_clr = 1'b0;
    mute_clr = 1'b0;
    settle(10);
    check("flags cleared", 2'h0, calm);
    check("analog back", 1'b1, aen);
    stop_test();
  end
endmodule : tb
